// ### logic/audio_irq_flags.sv
// sticky pending flags, one per interrupt source
module audio_irq_flags
(
    input  wire logic  ref_clk_i,
    input  wire logic  rst_i,
    input  wire logic  clk_en_i,
    audio_irq_if.bank  irq
);
    logic [3:0] pending_reg;
    logic [3:0] pending_next;

    genvar g;
    generate
        for (g = 0; g < audio_port_pkg::IRQ_SOURCES; g++)
        begin : gen_flag
            // set wins over a simultaneous clear so no event is lost
            always_comb
            begin
                if (irq.enable[g] && irq.event_hit[g])
                    pending_next[g] = 1'b1;
                else if (irq.clear[g])
                    pending_next[g] = 1'b0;
                else
                    pending_next[g] = pending_reg[g];
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            pending_reg <= audio_port_pkg::IRQ_PENDING_RESET;
        else if (clk_en_i)
            pending_reg <= pending_next;
    end

    assign irq.pending = pending_reg;
endmodule

// ### logic/audio_irq_if.sv
// event and flag bundle between the top and the interrupt flag bank
interface audio_irq_if;
    logic [3:0] enable;
    logic [3:0] event_hit;
    logic [3:0] clear;
    logic [3:0] pending;

    modport ctrl
    (
        output enable,
        output event_hit,
        output clear,
        input  pending
    );
    modport bank
    (
        input  enable,
        input  event_hit,
        input  clear,
        output pending
    );
endinterface

// ### logic/audio_port_enable_irq_ctrl.sv
// audio port global enable, mode select and interrupt status/control
module audio_port_enable_irq_ctrl
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    input  wire logic        reg_sel_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_ack_o,
    input  wire logic [4:0]  rx_fifo_count_i,
    input  wire logic [3:0]  rx_warning_level_i,
    input  wire logic        rx_word_done_i,
    input  wire logic        rx_fifo_full_i,
    input  wire logic        rx_overrun_flag_i,
    input  wire logic        tx_almost_empty_flag_i,
    input  wire logic        tx_underrun_flag_i,
    output logic             port_clk_gate_o,
    output logic             port_enable_o,
    output logic             isdn_link_mode_o,
    output logic             bit_clk_external_o,
    output logic             frame_sync_external_o,
    output logic             irq_o
);
    audio_irq_if irq_bus ();

    logic [15:0]               cfg_reg;
    logic [15:0]               cfg_next;
    logic [3:0]                irq_en_reg;
    logic [3:0]                irq_en_next;
    logic [15:0]               rdata_reg;
    logic [15:0]               rdata_next;
    logic                      ack_reg;
    logic                      ack_next;
    logic [3:0]                src_prev_reg;
    logic [3:0]                src_prev_next;
    logic [3:0]                src_level;
    logic [3:0]                clear_strobe;
    logic [3:0]                irq_pending;
    logic                      clk_on;
    logic                      access_ok;
    logic                      rx_cond;
    audio_port_pkg::port_state_t port_state;

    assign clk_on    = cfg_reg[audio_port_pkg::CFG_CLK_EN_BIT];
    // only the global config register answers while the port clock is gated off
    assign access_ok = clk_on;

    // receive condition is masked during a discarded overrun word
    always_comb
    begin
        rx_cond = ({1'b0, rx_warning_level_i} < rx_fifo_count_i);
        if (rx_word_done_i && rx_fifo_full_i)
            rx_cond = 1'b0;
    end

    always_comb
    begin
        src_level = 4'h0;
        src_level[audio_port_pkg::SRC_RX]     = rx_cond;
        src_level[audio_port_pkg::SRC_RX_ERR] = rx_overrun_flag_i;
        src_level[audio_port_pkg::SRC_TX]     = tx_almost_empty_flag_i;
        src_level[audio_port_pkg::SRC_TX_ERR] = tx_underrun_flag_i;
    end

    always_comb
    begin
        src_prev_next = src_level;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            src_prev_reg <= 4'h0;
        else if (clk_en_i)
            src_prev_reg <= src_prev_next;
    end

    // receive is a level condition; the other three fire on the flag rising
    always_comb
    begin
        irq_bus.event_hit = src_level & ~src_prev_reg;
        irq_bus.event_hit[audio_port_pkg::SRC_RX] = rx_cond;
    end
    // edge memory stops a flag that stays high from re-raising after clear

    // config write: clock enable must already be set, else only the clock enable bit is taken
    always_comb
    begin
        cfg_next    = cfg_reg;
        irq_en_next = irq_en_reg;
        clear_strobe = 4'h0;
        if (reg_wr_i)
        begin
            if (reg_sel_i == audio_port_pkg::SEL_GLOBAL_CONFIG)
            begin
                if (access_ok)
                    cfg_next = reg_wdata_i;
                else
                begin
                    // only the clock enable takes before the clock runs
                    cfg_next = audio_port_pkg::CFG_RESET;
                    cfg_next[audio_port_pkg::CFG_CLK_EN_BIT] =
                        reg_wdata_i[audio_port_pkg::CFG_CLK_EN_BIT];
                end
            end
            else if (access_ok)
            begin
                irq_en_next = reg_wdata_i[audio_port_pkg::IRQ_ENABLE_LSB +: 4];
                // a zero in a clear bit leaves the flag alone
                clear_strobe =
                    reg_wdata_i[audio_port_pkg::IRQ_CLEAR_LSB +: 4];
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_reg    <= audio_port_pkg::CFG_RESET;
            irq_en_reg <= audio_port_pkg::IRQ_ENABLE_RESET;
        end
        else if (clk_en_i)
        begin
            cfg_reg    <= cfg_next;
            irq_en_reg <= irq_en_next;
        end
    end

    assign irq_bus.enable = irq_en_reg;
    assign irq_bus.clear  = clear_strobe;
    assign irq_pending    = irq_bus.pending;

    audio_irq_flags u_flags
    (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .clk_en_i  (clk_en_i),
        .irq       (irq_bus.bank)
    );
    // the bank clears only the flags whose clear bit was written as one

    // read data is registered; gated clock returns zero for the interrupt register
    always_comb
    begin
        rdata_next = 16'h0000;
        ack_next   = reg_rd_i | reg_wr_i;
        if (reg_rd_i && access_ok)
        begin
            if (reg_sel_i == audio_port_pkg::SEL_GLOBAL_CONFIG)
                rdata_next = cfg_reg;
            else if (reg_sel_i == audio_port_pkg::SEL_IRQ_STATUS_CTRL)
            begin
                rdata_next[audio_port_pkg::IRQ_ENABLE_LSB +: 4] =
                    irq_en_reg;
                rdata_next[audio_port_pkg::IRQ_PENDING_LSB +: 4] =
                    irq_pending;
                // clear and reserved bits stay zero on read
                rdata_next[15:8] = 8'h00;
            end
        end
        else if (reg_rd_i && !access_ok && reg_sel_i ==
                 audio_port_pkg::SEL_GLOBAL_CONFIG)
            rdata_next = cfg_reg;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_reg <= 16'h0000;
            ack_reg   <= 1'b0;
        end
        else if (clk_en_i)
        begin
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
        end
    end

    // port state decode from clock, unit enable and mode bits
    always_comb
    begin
        if (!clk_on)
            port_state = audio_port_pkg::PORT_OFF;
        else if (!cfg_reg[audio_port_pkg::CFG_UNIT_EN_BIT])
            port_state = audio_port_pkg::PORT_CLK_ONLY;
        else if (cfg_reg[audio_port_pkg::CFG_ISDN_MODE_BIT])
            port_state = audio_port_pkg::PORT_ISDN;
        else
            port_state = audio_port_pkg::PORT_PCM;
    end

    always_comb
    begin
        port_clk_gate_o       = 1'b0;
        port_enable_o         = 1'b0;
        isdn_link_mode_o      = 1'b0;
        bit_clk_external_o    = 1'b0;
        frame_sync_external_o = 1'b0;
        case (port_state)
            audio_port_pkg::PORT_OFF:
                port_clk_gate_o = 1'b0;
            audio_port_pkg::PORT_CLK_ONLY:
                port_clk_gate_o = 1'b1;
            audio_port_pkg::PORT_PCM:
            begin
                port_clk_gate_o = 1'b1;
                port_enable_o   = 1'b1;
            end
            audio_port_pkg::PORT_ISDN:
            begin
                port_clk_gate_o       = 1'b1;
                port_enable_o         = 1'b1;
                isdn_link_mode_o      = 1'b1;
                // slave only: both clocks come from the isdn controller
                bit_clk_external_o    = 1'b1;
                frame_sync_external_o = 1'b1;
            end
            default:
                port_clk_gate_o = 1'b0;
        endcase
    end

    assign reg_rdata_o = rdata_reg;
    assign reg_ack_o   = ack_reg;
    assign irq_o       = |irq_pending;
endmodule

// ### logic/audio_port_pkg.sv
// shared constants and types for the audio port enable and interrupt block
package audio_port_pkg;
    // global configuration register, upper byte bits (15 down to 8)
    localparam int unsigned CFG_ISDN_MODE_BIT   = 13;
    localparam int unsigned CFG_UNIT_EN_BIT     = 14;
    localparam int unsigned CFG_CLK_EN_BIT      = 15;
    localparam logic [15:0] CFG_RESET           = 16'h0000;
    // interrupt status and control register field positions
    localparam int unsigned IRQ_ENABLE_LSB      = 0;
    localparam int unsigned IRQ_PENDING_LSB     = 4;
    localparam int unsigned IRQ_CLEAR_LSB       = 8;
    localparam int unsigned IRQ_SOURCES         = 4;
    localparam logic [3:0]  IRQ_ENABLE_RESET    = 4'h0;
    localparam logic [3:0]  IRQ_PENDING_RESET   = 4'h0;
    // source index: rx, rx error, tx, tx error
    localparam int unsigned SRC_RX              = 0;
    localparam int unsigned SRC_RX_ERR          = 1;
    localparam int unsigned SRC_TX              = 2;
    localparam int unsigned SRC_TX_ERR          = 3;
    // register select codes
    localparam logic        SEL_GLOBAL_CONFIG   = 1'b0;
    localparam logic        SEL_IRQ_STATUS_CTRL = 1'b1;
    localparam logic [3:0]  RX_LEVEL_RESET      = 4'h0;
    localparam logic [4:0]  RX_COUNT_RESET      = 5'h00;

    typedef enum logic [1:0]
    {
        PORT_OFF      = 2'b00,
        PORT_CLK_ONLY = 2'b01,
        PORT_PCM      = 2'b10,
        PORT_ISDN     = 2'b11
    } port_state_t;
endpackage

// ### verif/audio_port_asserts.sv
// concurrent checks on the audio port enable and interrupt block
module audio_port_asserts
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    input  wire logic        reg_sel_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic [15:0] reg_rdata_o,
    input  wire logic        reg_ack_o,
    input  wire logic        port_clk_gate_o,
    input  wire logic        port_enable_o,
    input  wire logic        isdn_link_mode_o,
    input  wire logic        bit_clk_external_o,
    input  wire logic        frame_sync_external_o,
    input  wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic req;
    assign req = clk_en_i && (reg_wr_i || reg_rd_i);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (req |=> reg_ack_o)
        else $error("ack missing after request");
    a_ack_only: assert property (!req |=> !reg_ack_o)
        else $error("ack without request");
    a_isdn_slave: assert property (isdn_link_mode_o |->
        bit_clk_external_o && frame_sync_external_o)
        else $error("isdn mode without external clocks");
    a_mode_gated: assert property (isdn_link_mode_o |-> port_enable_o)
        else $error("isdn mode while port off");
    a_enable_gated: assert property (port_enable_o |-> port_clk_gate_o)
        else $error("port on without clock");
    a_irq_read_off: assert property (req && reg_rd_i && reg_sel_i &&
        !port_clk_gate_o |=> reg_rdata_o == 16'h0000)
        else $error("irq register readable with clock off");
    a_cfg_refused: assert property (req && reg_wr_i && !reg_sel_i &&
        !port_clk_gate_o |=> !port_enable_o)
        else $error("unit enabled before clock enable");
    a_clear_reads_zero: assert property (req && reg_rd_i && reg_sel_i
        |=> reg_rdata_o[15:8] == 8'h00)
        else $error("clear or reserved bits read nonzero");
    a_pending_sticky: assert property (irq_o && !(req && reg_wr_i &&
        reg_sel_i && |reg_wdata_i[11:8]) |=> irq_o)
        else $error("interrupt dropped without a clear");
endmodule

bind audio_port_enable_irq_ctrl audio_port_asserts chk_u
(
    .ref_clk_i, .rst_i, .clk_en_i, .reg_sel_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .port_clk_gate_o,
    .port_enable_o, .isdn_link_mode_o, .bit_clk_external_o,
    .frame_sync_external_o, .irq_o
);

// ### verif/icu_model.sv
// interrupt control unit stand-in: counts requests from the port
module icu_model
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       irq_i,
    output logic      [7:0] irq_count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic irq_reg;
    // a level request counts once, on its leading edge
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_reg     <= 1'b0;
            irq_count_o <= 8'h00;
        end
        else
        begin
            irq_reg <= irq_i;
            if (irq_i && !irq_reg)
                irq_count_o <= irq_count_o + 8'h01;
        end
    end
endmodule

// ### verif/tb_top.sv
// self-checking bench for the audio port enable and interrupt block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        clk_en_i = 1'b1;
    logic        reg_sel_i = 1'b0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [4:0]  rx_fifo_count_i = 5'h00;
    logic [3:0]  rx_warning_level_i = 4'h0;
    logic        rx_word_done_i = 1'b0;
    logic        rx_fifo_full_i = 1'b0;
    logic [3:0]  flag = 4'h0;
    logic [15:0] reg_rdata_o;
    logic        reg_ack_o, port_clk_gate_o, port_enable_o, irq_o;
    logic        isdn_link_mode_o, bit_clk_external_o, frame_sync_external_o;
    logic [7:0]  irq_count;
    int          err_count = 0;
    int          comparisons = 0;

    audio_port_enable_irq_ctrl dut_u
    (
        .ref_clk_i, .rst_i, .clk_en_i, .reg_sel_i, .reg_wr_i, .reg_rd_i,
        .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .rx_fifo_count_i,
        .rx_warning_level_i, .rx_word_done_i, .rx_fifo_full_i,
        .rx_overrun_flag_i(flag[1]), .tx_almost_empty_flag_i(flag[2]),
        .tx_underrun_flag_i(flag[3]), .port_clk_gate_o, .port_enable_o,
        .isdn_link_mode_o, .bit_clk_external_o, .frame_sync_external_o,
        .irq_o
    );
    icu_model icu_u
    (
        .ref_clk_i, .rst_i, .irq_i(irq_o), .irq_count_o(irq_count)
    );

    initial
    begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    task automatic print_verdict;
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] seen,
                       input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // one-cycle strobe, then a bounded wait for the registered ack
    task automatic xfer(input logic rd, input logic s, input logic [15:0] d);
        int i;
        @(posedge ref_clk_i);
        reg_sel_i <= s;
        reg_wdata_i <= d;
        reg_wr_i <= !rd;
        reg_rd_i <= rd;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1;
        for (i = 0; i < 4 && reg_ack_o !== 1'b1; i++)
        begin
            @(posedge ref_clk_i);
            #1;
        end
        if (reg_ack_o !== 1'b1)
        begin
            err_count++;
            print_verdict();
        end
    endtask

    task automatic rdchk(input logic s, input logic [15:0] e, input string n);
        xfer(1'b1, s, 16'h0000);
        chk(n, reg_rdata_o, e);
    endtask

    // source 0 is the receive fifo level, the rest are flag inputs
    task automatic raise(input int k, input logic v);
        @(posedge ref_clk_i);
        if (k == 0)
            rx_fifo_count_i <= v ? 5'h01 : 5'h00;
        else
            flag[k] <= v;
    endtask

    initial
    begin
        int k;
        logic [15:0] exp;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rdchk(1'b0, 16'h0000, "cfg_reset");
        chk("gate_reset", 16'(port_clk_gate_o), 16'h0000);
        rdchk(1'b1, 16'h0000, "irq_reset");
        xfer(1'b0, 1'b1, 16'h000f);
        xfer(1'b0, 1'b0, 16'he000);
        rdchk(1'b0, 16'h8000, "cfg_clock_first");
        chk("clk_gate", 16'(port_clk_gate_o), 16'h0001);
        rdchk(1'b1, 16'h0000, "irq_clock_off");
        xfer(1'b0, 1'b0, 16'hc000);
        chk("unit_on", 16'({port_enable_o, isdn_link_mode_o}),
            16'h0002);
        xfer(1'b0, 1'b0, 16'he000);
        chk("isdn", 16'({isdn_link_mode_o, bit_clk_external_o,
            frame_sync_external_o}), 16'h0007);
        xfer(1'b0, 1'b0, 16'h8000);
        chk("unit_off", 16'({port_enable_o, isdn_link_mode_o}),
            16'h0000);
        xfer(1'b0, 1'b1, 16'hf0ff);
        rdchk(1'b1, 16'h000f, "irq_rw");
        for (k = 0; k < 4; k++)
        begin
            raise(k, 1'b1);
            repeat (2) @(posedge ref_clk_i);
            raise(k, 1'b0);
            exp = 16'h000f | (16'h0010 << k);
            rdchk(1'b1, exp, "pending_set");
            xfer(1'b0, 1'b1, 16'h000f);
            rdchk(1'b1, exp, "zero_clear");
            chk("irq_out", 16'(irq_o), 16'h0001);
            xfer(1'b0, 1'b1, 16'h000f | (16'h0100 << k));
            rdchk(1'b1, 16'h000f, "one_clear");
        end
        chk("icu_count", 16'(irq_count), 16'h0004);
        xfer(1'b0, 1'b1, 16'h0000);
        for (k = 0; k < 4; k++)
            raise(k, 1'b1);
        rdchk(1'b1, 16'h0000, "masked");
        chk("irq_masked", 16'(irq_o), 16'h0000);
        for (k = 0; k < 4; k++)
            raise(k, 1'b0);
        xfer(1'b0, 1'b1, 16'h0001);
        @(posedge ref_clk_i);
        rx_warning_level_i <= 4'h3;
        rx_fifo_count_i <= 5'h03;
        rdchk(1'b1, 16'h0001, "at_level");
        @(posedge ref_clk_i);
        rx_fifo_count_i <= 5'h04;
        rdchk(1'b1, 16'h0011, "above_level");
        raise(0, 1'b0);
        xfer(1'b0, 1'b1, 16'h0101);
        @(posedge ref_clk_i);
        rx_fifo_count_i <= 5'h05;
        rx_word_done_i <= 1'b1;
        rx_fifo_full_i <= 1'b1;
        @(posedge ref_clk_i);
        rx_fifo_count_i <= 5'h00;
        rx_word_done_i <= 1'b0;
        rx_fifo_full_i <= 1'b0;
        rdchk(1'b1, 16'h0001, "full_drop");
        // a low clock enable must hold off an enabled tx event until thaw
        xfer(1'b0, 1'b1, 16'h0004);
        @(posedge ref_clk_i);
        clk_en_i <= 1'b0;
        raise(2, 1'b1);
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("frozen", 16'(irq_o), 16'h0000);
        @(posedge ref_clk_i);
        clk_en_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rdchk(1'b1, 16'h0044, "thawed");
        print_verdict();
    end
endmodule
